// ==== logic/psa_defines.svh ====
// offsets, field positions, reset values and timing counts of the annunciator
`ifndef PSA_DEFINES_SVH
`define PSA_DEFINES_SVH

// register byte offsets
`define PSA_OFS_CTRL        6'h00
`define PSA_OFS_HIGH_SP     6'h04
`define PSA_OFS_OVER_SP     6'h08
`define PSA_OFS_UNDER_SP    6'h0C
`define PSA_OFS_ACTIVE      6'h10
`define PSA_OFS_UNVIEWED    6'h14
`define PSA_OFS_TELEM       6'h18
`define PSA_OFS_IRQ_STATUS  6'h1C
`define PSA_OFS_IRQ_MASK    6'h20
`define PSA_OFS_OUTPUTS     6'h24

// control register fields
`define PSA_CTRL_AUX_EN     0
`define PSA_CTRL_AUX_CLOSED 1
`define PSA_CTRL_ANALOG     2
`define PSA_CTRL_REMOTE     3

// reset values
`define PSA_CTRL_RST        4'h0
`define PSA_HIGH_SP_RST     16'hFFFF
`define PSA_OVER_SP_RST     16'hFFFF
`define PSA_UNDER_SP_RST    16'h0000

// timing
`define PSA_CLK_HZ          100000000
`define PSA_FLOAT_HOLD_H    24
`define PSA_SEC_PER_HOUR    3600
`define PSA_FLASH_HALF_MS   500

`endif

// ==== logic/psa_pkg.sv ====
// types shared by the pump station alarm annunciator
package psa_pkg;

   // alarm bit positions, in this order
   typedef enum logic [3:0] {
      PSA_FLOAT_ORDER,
      PSA_START_FAIL,
      PSA_STOP_FAIL,
      PSA_HIGH_LEVEL,
      PSA_LOW_LEVEL,
      PSA_BIAS_SUPPLY,
      PSA_MAINS_LOSS,
      PSA_TRANSDUCER,
      PSA_PHASE_VOLTAGE,
      PSA_PHASE_ORDER,
      PSA_SPARE_CONTACT
   } psa_alarm_idx_t;

   typedef logic [10:0] psa_alarm_vec_t;
   typedef logic [7:0]  psa_slot_vec_t;

   // field pins, all asynchronous to core_clk
   typedef struct packed {
      logic [3:0] level_floats;    // off, lead, lag, high float (bit 3)
      logic       spare_contact;   // 1 = contact closed
      logic       bias_fault;      // isolated bias supply out of limits
      logic       mains_present;
      logic       on_battery;
      logic       phase_missing;
      logic       phase_reversed;
      logic [2:0] hand_switch;     // manual override per pump
   } psa_pins_t;

   // line voltage measurements from the analog front end
   typedef struct packed {
      logic [15:0] line_ab;
      logic [15:0] line_ac;
   } psa_volts_t;

endpackage

// ==== logic/psa_annunciator.sv ====
// pump station alarm annunciator with avalon-mm register slave
//
// Overview of operation
// - lamp lit while alarms unviewed; flashes if any active, steady otherwise
// - message flashes while active, turns static when condition clears
// - cleared alarm kept in log until viewed, then removed from display
// - lamp goes off on leaving alarm screen when nothing active
// - active alarms shown locally and reported to telemetry when remote
// - telemetry cannot clear messages or lamp; only local screen can
// - mains loss alarm when ac interrupted, detectable only on battery
// - spare contact alarm when enabled and contact in chosen state
// - bias supply alarm whenever isolated bias supply is faulty
// - float order alarm on out-of-sequence floats, held till viewed or 24h
// - telemetry float order clears at next pump cycle without fault
// - high level from high float, or analog level above set point
// - phase fault disables pump outputs, energises light and horn relays
// - phase order alarm also on missing phase or power interruption
// - manual override switches run pumps despite a phase fault
// - phase voltage fault when line voltage outside over/under set points
// - three alarm pairs share display slots
// - leaving alarm screen purges every inactive alarm from log
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "psa_defines.svh"

module psa_annunciator #(
   parameter logic [47:0] FLOAT_HOLD_CYCLES =
      48'(`PSA_FLOAT_HOLD_H) * 48'(`PSA_SEC_PER_HOUR) * 48'(`PSA_CLK_HZ),
   parameter logic [31:0] FLASH_HALF_CYCLES =
      32'(`PSA_FLASH_HALF_MS * (`PSA_CLK_HZ / 1000))
) (
   // clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   // avalon-mm slave
   input  wire logic [5:0]              avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [31:0]             avs_writedata,
   input  wire logic [3:0]              avs_byteenable,
   output logic [31:0]                  avs_readdata,
   output logic                         avs_waitrequest,
   output logic                         irq,
   // field pins
   input  wire psa_pkg::psa_pins_t      pins,
   // conditions from on-chip pump and measurement logic
   input  wire psa_pkg::psa_volts_t     volts,
   input  wire logic [15:0]             level_value,
   input  wire logic                    start_fail_in,
   input  wire logic                    stop_fail_in,
   input  wire logic                    low_level_in,
   input  wire logic                    transducer_in,
   input  wire logic                    pump_cycle_done,
   input  wire logic [2:0]              pump_auto_req,
   // local operator screen
   input  wire logic                    screen_open,
   // outputs
   output logic [2:0]                   pump_out,
   output logic                         alarm_light_relay,
   output logic                         horn_relay,
   output logic                         alarm_lamp,
   output psa_pkg::psa_slot_vec_t       slot_shown,
   output psa_pkg::psa_slot_vec_t       slot_flash,
   output psa_pkg::psa_slot_vec_t       slot_second,
   output psa_pkg::psa_alarm_vec_t      telem_alarms
);

   // ==========================================================
   // functions
   // ==========================================================
   // a higher float on while a lower one is off is out of order
   function automatic logic floats_bad(input logic [3:0] f);
      floats_bad = (f[3] & ~f[2]) | (f[2] & ~f[1]) | (f[1] & ~f[0]);
   endfunction

   function automatic logic out_of_range(input logic [15:0] v,
                                         input logic [15:0] hi,
                                         input logic [15:0] lo);
      out_of_range = (v > hi) | (v < lo);
   endfunction

   // fold eleven alarms into eight display slots
   function automatic psa_pkg::psa_slot_vec_t to_slots(
         input psa_pkg::psa_alarm_vec_t a);
      to_slots = {a[10], a[9] | a[8], a[7], a[6], a[5], a[4] | a[3],
                  a[2] | a[1], a[0]};
   endfunction

   // ==========================================================
   // pin synchronisers
   // ==========================================================
   psa_pkg::psa_pins_t pins_meta_reg;
   psa_pkg::psa_pins_t pins_sync_reg;

   // two stages; only the second stage is read below
   always_ff @(posedge core_clk) begin
      if (rst) begin
         // idle with mains present, so reset alone sets no phase event
         pins_meta_reg <= '{mains_present: 1'b1, default: '0};
         pins_sync_reg <= '{mains_present: 1'b1, default: '0};
      end else begin
         pins_meta_reg <= pins;
         pins_sync_reg <= pins_meta_reg;
      end
   end

   // ==========================================================
   // register file
   // ==========================================================
   logic [3:0]               ctrl_reg;
   logic [15:0]              high_sp_reg;
   logic [15:0]              over_sp_reg;
   logic [15:0]              under_sp_reg;
   psa_pkg::psa_alarm_vec_t  irq_status_reg;
   psa_pkg::psa_alarm_vec_t  irq_mask_reg;
   logic                     ack_reg;
   logic                     wr_fire;
   logic [31:0]              wmask;
   logic [31:0]              wdata_m;
   logic [31:0]              rd_next;

   // one wait state per access; write lands when waitrequest is low
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
   assign wr_fire         = avs_write & ack_reg;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wdata_m = avs_writedata & wmask;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (avs_read | avs_write) & ~ack_reg;
      end
   end

   // writable configuration; the log registers have no write path,
   // so a telemetry master on this bus cannot clear them
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_reg     <= `PSA_CTRL_RST;
         high_sp_reg  <= `PSA_HIGH_SP_RST;
         over_sp_reg  <= `PSA_OVER_SP_RST;
         under_sp_reg <= `PSA_UNDER_SP_RST;
         irq_mask_reg <= '0;
      end else if (wr_fire) begin
         unique case (avs_address)
            `PSA_OFS_CTRL: begin
               ctrl_reg <= (ctrl_reg & ~wmask[3:0]) | wdata_m[3:0];
            end
            `PSA_OFS_HIGH_SP: begin
               high_sp_reg <= (high_sp_reg & ~wmask[15:0]) | wdata_m[15:0];
            end
            `PSA_OFS_OVER_SP: begin
               over_sp_reg <= (over_sp_reg & ~wmask[15:0]) | wdata_m[15:0];
            end
            `PSA_OFS_UNDER_SP: begin
               under_sp_reg <= (under_sp_reg & ~wmask[15:0])
                               | wdata_m[15:0];
            end
            `PSA_OFS_IRQ_MASK: begin
               irq_mask_reg <= (irq_mask_reg & ~wmask[10:0])
                               | wdata_m[10:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // alarm conditions
   // ==========================================================
   logic                     float_now;
   logic                     high_level_now;
   logic                     volt_fault_now;
   logic                     phase_order_now;
   logic                     phase_fault;
   logic                     mains_loss_now;
   logic                     spare_now;
   logic                     float_local_reg;
   logic                     float_telem_reg;
   logic                     cycle_fault_reg;
   logic [47:0]              float_age_reg;
   psa_pkg::psa_alarm_vec_t  active;

   assign float_now = floats_bad(pins_sync_reg.level_floats);
   // analog mode compares against the set point, else the high float
   assign high_level_now = ctrl_reg[`PSA_CTRL_ANALOG]
                           ? (level_value > high_sp_reg)
                           : pins_sync_reg.level_floats[3];
   assign volt_fault_now =
      out_of_range(volts.line_ab, over_sp_reg, under_sp_reg) |
      out_of_range(volts.line_ac, over_sp_reg, under_sp_reg);
   assign phase_order_now = pins_sync_reg.phase_reversed |
                            pins_sync_reg.phase_missing |
                            ~pins_sync_reg.mains_present;
   // without the battery the block is unpowered, so no alarm then
   assign mains_loss_now = pins_sync_reg.on_battery &
                           ~pins_sync_reg.mains_present;
   assign spare_now = ctrl_reg[`PSA_CTRL_AUX_EN] &
                      (pins_sync_reg.spare_contact
                       == ctrl_reg[`PSA_CTRL_AUX_CLOSED]);
   assign phase_fault = pins_sync_reg.phase_missing |
                        pins_sync_reg.phase_reversed |
                        volt_fault_now;

   // local float alarm: held until viewed or hold time expires
   always_ff @(posedge core_clk) begin
      if (rst) begin
         float_local_reg <= 1'b0;
         float_age_reg   <= '0;
      end else if (float_now) begin
         float_local_reg <= 1'b1;
         float_age_reg   <= '0;
      end else if (float_local_reg) begin
         if (screen_open || float_age_reg >= FLOAT_HOLD_CYCLES - 48'h1) begin
            float_local_reg <= 1'b0;
            float_age_reg   <= '0;
         end else begin
            float_age_reg <= float_age_reg + 48'h1;
         end
      end
   end

   // telemetry float alarm ends with a clean pump cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         float_telem_reg <= 1'b0;
         cycle_fault_reg <= 1'b0;
      end else begin
         if (float_now) begin
            float_telem_reg <= 1'b1;
         end else if (pump_cycle_done && !cycle_fault_reg) begin
            float_telem_reg <= 1'b0;
         end
         if (pump_cycle_done) begin
            cycle_fault_reg <= float_now;
         end else if (float_now) begin
            cycle_fault_reg <= 1'b1;
         end
      end
   end

   always_comb begin
      active = '0;
      active[psa_pkg::PSA_FLOAT_ORDER]   = float_local_reg | float_now;
      active[psa_pkg::PSA_START_FAIL]    = start_fail_in;
      active[psa_pkg::PSA_STOP_FAIL]     = stop_fail_in;
      active[psa_pkg::PSA_HIGH_LEVEL]    = high_level_now;
      active[psa_pkg::PSA_LOW_LEVEL]     = low_level_in;
      active[psa_pkg::PSA_BIAS_SUPPLY]   = pins_sync_reg.bias_fault;
      active[psa_pkg::PSA_MAINS_LOSS]    = mains_loss_now;
      active[psa_pkg::PSA_TRANSDUCER]    = transducer_in;
      active[psa_pkg::PSA_PHASE_VOLTAGE] = volt_fault_now;
      active[psa_pkg::PSA_PHASE_ORDER]   = phase_order_now;
      active[psa_pkg::PSA_SPARE_CONTACT] = spare_now;
   end

   // ==========================================================
   // alarm log and lamp
   // ==========================================================
   psa_pkg::psa_alarm_vec_t  unviewed_reg;
   psa_pkg::psa_alarm_vec_t  active_prev_reg;
   logic                     screen_prev_reg;
   logic                     screen_leave;
   logic [31:0]              flash_cnt_reg;
   logic                     flash_reg;
   logic                     any_active;
   logic                     any_unviewed;

   assign screen_leave = screen_prev_reg & ~screen_open;

   // active alarms always enter the log; inactive ones leave it when
   // seen on screen or when the screen is exited
   always_ff @(posedge core_clk) begin
      if (rst) begin
         unviewed_reg    <= '0;
         screen_prev_reg <= 1'b0;
      end else begin
         screen_prev_reg <= screen_open;
         if (screen_open || screen_leave) begin
            unviewed_reg <= active;
         end else begin
            unviewed_reg <= unviewed_reg | active;
         end
      end
   end

   // flash divider: toggles every half period
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flash_cnt_reg <= '0;
         flash_reg     <= 1'b0;
      end else if (flash_cnt_reg >= FLASH_HALF_CYCLES - 32'h1) begin
         flash_cnt_reg <= '0;
         flash_reg     <= ~flash_reg;
      end else begin
         flash_cnt_reg <= flash_cnt_reg + 32'h1;
      end
   end

   assign any_active   = |active;
   assign any_unviewed = |unviewed_reg;

   // lamp and display, registered
   always_ff @(posedge core_clk) begin
      if (rst) begin
         alarm_lamp  <= 1'b0;
         slot_shown  <= '0;
         slot_flash  <= '0;
         slot_second <= '0;
      end else begin
         // after exit the log holds only active alarms, so lamp drops when none is active
         alarm_lamp  <= any_active ? flash_reg : any_unviewed;
         slot_shown  <= to_slots(unviewed_reg | active);
         slot_flash  <= flash_reg ? to_slots(active) : '0;
         // second member of stop, low and phase order pairs, alone only
         slot_second <= to_slots(active & ~(active << 1) & 11'h214);
      end
   end

   // ==========================================================
   // pump gating, relays, telemetry
   // ==========================================================
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pump_out          <= '0;
         alarm_light_relay <= 1'b0;
         horn_relay        <= 1'b0;
         telem_alarms      <= '0;
      end else begin
         // hand switches bypass the phase monitor on purpose
         pump_out <= (pump_auto_req & {3{~phase_fault}})
                     | pins_sync_reg.hand_switch;
         alarm_light_relay <= phase_fault;
         horn_relay        <= phase_fault;
         if (ctrl_reg[`PSA_CTRL_REMOTE]) begin
            telem_alarms <= {active[10:1], float_telem_reg};
         end else begin
            telem_alarms <= '0;
         end
      end
   end

   // ==========================================================
   // interrupts and read data
   // ==========================================================
   // new activations set sticky bits; a set beats a same-cycle clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_status_reg  <= '0;
         active_prev_reg <= '0;
         irq             <= 1'b0;
      end else begin
         active_prev_reg <= active;
         if (wr_fire && avs_address == `PSA_OFS_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~wdata_m[10:0])
                              | (active & ~active_prev_reg);
         end else begin
            irq_status_reg <= irq_status_reg | (active & ~active_prev_reg);
         end
         irq <= |(irq_status_reg & irq_mask_reg);
      end
   end

   always_comb begin
      rd_next = 32'h0;
      unique case (avs_address)
         `PSA_OFS_CTRL:       rd_next = {28'h0, ctrl_reg};
         `PSA_OFS_HIGH_SP:    rd_next = {16'h0, high_sp_reg};
         `PSA_OFS_OVER_SP:    rd_next = {16'h0, over_sp_reg};
         `PSA_OFS_UNDER_SP:   rd_next = {16'h0, under_sp_reg};
         `PSA_OFS_ACTIVE:     rd_next = {21'h0, active};
         `PSA_OFS_UNVIEWED:   rd_next = {21'h0, unviewed_reg};
         `PSA_OFS_TELEM:      rd_next = {21'h0, telem_alarms};
         `PSA_OFS_IRQ_STATUS: rd_next = {21'h0, irq_status_reg};
         `PSA_OFS_IRQ_MASK:   rd_next = {21'h0, irq_mask_reg};
         `PSA_OFS_OUTPUTS:    rd_next = {26'h0, pump_out, horn_relay,
                                         alarm_light_relay, alarm_lamp};
         default:             rd_next = 32'h0;
      endcase
   end

   // captured in the wait cycle, stands while waitrequest is low
   always_ff @(posedge core_clk) begin
      if (rst) begin
         avs_readdata <= '0;
      end else if (avs_read && !ack_reg) begin
         avs_readdata <= rd_next;
      end
   end

endmodule // psa_annunciator
`default_nettype wire

// ==== sim/psa_field.sv ====
// field side model: float switches, contacts, supplies and phase monitor
`timescale 1ns/10ps
`default_nettype none

module psa_field (
   // clock
   input  wire logic         core_clk,
   // scenario controls: contact bias mains_off battery lost reversed
   input  wire logic [2:0]   depth,
   input  wire logic         swap,
   input  wire logic [5:0]   fault,
   input  wire logic [2:0]   hand,
   // pins seen by the annunciator
   output psa_pkg::psa_pins_t pins
);
   // ===========================================================
   // floats close bottom up; swap leaves the top one on alone
   always_ff @(posedge core_clk) begin
      pins.level_floats   <= swap ? 4'h8 : 4'((5'h01 << depth) - 5'h01);
      pins.spare_contact  <= fault[0];
      pins.bias_fault     <= fault[1];
      pins.mains_present  <= !fault[2];
      pins.on_battery     <= fault[3];
      pins.phase_missing  <= fault[4];
      pins.phase_reversed <= fault[5];
      pins.hand_switch    <= hand;
   end
endmodule // psa_field

`default_nettype wire

// ==== sim/psa_annunciator_checker.sv ====
// port-level assertions for the pump station alarm annunciator
`timescale 1ns/10ps
`default_nettype none

module psa_annunciator_checker (
   // clock and reset
   input wire logic                   core_clk,
   input wire logic                   rst,
   // bus handshake
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic                   avs_waitrequest,
   // field pins and outputs
   input wire psa_pkg::psa_pins_t     pins,
   input wire logic [2:0]             pump_out,
   input wire logic                   alarm_light_relay,
   input wire logic                   horn_relay,
   input wire logic                   alarm_lamp,
   input wire psa_pkg::psa_slot_vec_t slot_shown,
   input wire psa_pkg::psa_slot_vec_t slot_flash,
   input wire psa_pkg::psa_slot_vec_t slot_second
);
   // ===========================================================
   // pins need three edges to cross the synchroniser and output flop
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   relays_paired_a: assert property (
      alarm_light_relay == horn_relay) else $error("relays disagree");
   horn_on_fault_a: assert property (
      pins.phase_reversed [*5] |-> horn_relay) else $error("horn idle");
   pumps_gated_a: assert property (
      (pins.phase_missing && pins.hand_switch == 3'h0) [*5] |->
      pump_out == 3'h0) else $error("pump runs in phase fault");
   hand_wins_a: assert property (
      pins.hand_switch[0] [*5] |-> pump_out[0]) else $error("hand ignored");
   lamp_dark_a: assert property (
      (slot_shown == 8'h00) [*3] |-> !alarm_lamp) else $error("lamp lit");
   flash_shown_a: assert property (
      (slot_flash & ~slot_shown) == 8'h00) else $error("flash unshown");
   pair_second_a: assert property (
      (slot_second & ~(slot_shown & 8'h46)) == 8'h00)
      else $error("bad second member");
   one_wait_a: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("wait state too long");
   idle_wait_a: assert property (
      !(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("wait while idle");
endmodule // psa_annunciator_checker

bind psa_annunciator psa_annunciator_checker psa_annunciator_checker_inst (
   .core_clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .pins,
   .pump_out, .alarm_light_relay, .horn_relay, .alarm_lamp, .slot_shown,
   .slot_flash, .slot_second);

`default_nettype wire

// ==== sim/psa_annunciator_bench.sv ====
// self-checking bench for the pump station alarm annunciator
`timescale 1ns/10ps
`default_nettype none
`include "psa_defines.svh"

module psa_annunciator_bench;
   localparam logic [5:0] ACT = `PSA_OFS_ACTIVE;
   localparam logic [5:0] OUTS = `PSA_OFS_OUTPUTS;
   logic                    core_clk = 1'b0, rst = 1'b1;
   logic [5:0]              avs_address = 6'h00;
   logic                    avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0]             avs_writedata = 32'h0, avs_readdata, q;
   logic                    avs_waitrequest, irq, alarm_lamp;
   logic                    low_level_in = 1'b0, pump_cycle_done = 1'b0;
   logic                    screen_open = 1'b0, swap = 1'b0;
   logic                    alarm_light_relay, horn_relay, stop_fail_in = 1'b0;
   logic [2:0]              depth = 3'h0, hand = 3'h0, pump_out;
   logic [2:0]              pump_auto_req = 3'h0;
   logic [5:0]              fault = 6'h00;
   logic [15:0]             level_value = 16'h0000;
   psa_pkg::psa_pins_t      pins;
   psa_pkg::psa_volts_t     volts = 32'h012C012C;
   psa_pkg::psa_slot_vec_t  slot_shown, slot_flash, slot_second;
   psa_pkg::psa_alarm_vec_t telem_alarms;
   int                      miscompares = 0, checked = 0, hi;
   logic [5:0]  fset [8] = '{6'h01, 6'h02, 6'h04, 6'h0C, 6'h10, 6'h20, '0, '0};
   logic [31:0] etab [8] = '{32'h400, 32'h020, 32'h200, 32'h240, 32'h200,
                             32'h200, 32'h008, 32'h014};

   always #5 core_clk = ~core_clk;

   // short counts keep the hold and flash periods inside the run
   psa_annunciator #(.FLOAT_HOLD_CYCLES(48'd200), .FLASH_HALF_CYCLES(32'd4))
   psa_annunciator_inst (.core_clk, .rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
      .avs_waitrequest, .irq, .pins, .volts, .level_value,
      .start_fail_in(1'b0), .stop_fail_in, .low_level_in,
      .transducer_in(1'b0), .pump_cycle_done, .pump_auto_req, .screen_open,
      .pump_out, .alarm_light_relay, .horn_relay, .alarm_lamp, .slot_shown,
      .slot_flash, .slot_second, .telem_alarms);
   psa_field psa_field_inst (.core_clk, .depth, .swap, .fault, .hand, .pins);

   // ===========================================================
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input bit wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         check("waitrequest", 32'h0, avs_waitrequest);
         tally_and_finish();
      end
   endtask
   task automatic rd(input string w, input logic [5:0] a,
                     input logic [31:0] m, e);
      bus(1'b0, a, 32'h0);
      check(w, e, q & m);
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge core_clk);
   endtask
   task automatic view;
      @(posedge core_clk);
      screen_open <= 1'b1;
      settle(3);
      screen_open <= 1'b0;
      settle(6);
      @(negedge core_clk);
   endtask
   task automatic lamp_hi;
      hi = 0;
      repeat (16) begin
         @(negedge core_clk);
         hi += int'(alarm_lamp === 1'b1);
      end
   endtask
   task automatic pulse;
      @(posedge core_clk);
      pump_cycle_done <= 1'b1;
      @(posedge core_clk);
      pump_cycle_done <= 1'b0;
   endtask

   // ===========================================================
   initial begin
      settle(8);
      rst <= 1'b0;
      rd("ctrl", `PSA_OFS_CTRL, 32'hF, 32'h0);
      rd("high_sp", `PSA_OFS_HIGH_SP, 32'hFFFF, 32'hFFFF);
      rd("unmapped", 6'h3C, 32'hFFFFFFFF, 32'h0);
      bus(1'b1, `PSA_OFS_CTRL, 32'hB);
      bus(1'b1, `PSA_OFS_IRQ_MASK, 32'h7FF);
      swap <= 1'b1;
      settle(6);
      lamp_hi();
      check("lamp flash", 32'h1, hi > 0 && hi < 16);
      check("telem float", 32'h1, telem_alarms[0]);
      @(posedge core_clk);
      swap <= 1'b0;
      settle(20);
      rd("float held", ACT, 32'h1, 32'h1);
      bus(1'b1, `PSA_OFS_TELEM, 32'h0);
      view();
      check("telem kept", 32'h1, telem_alarms[0]);
      check("lamp off", 32'h0, alarm_lamp);
      rd("log", `PSA_OFS_UNVIEWED, 32'h7FF, 32'h0);
      pulse();
      pulse();
      settle(1);
      @(negedge core_clk);
      check("telem float", 32'h0, telem_alarms[0]);
      @(posedge core_clk);
      swap <= 1'b1;
      settle(6);
      swap <= 1'b0;
      settle(220);
      rd("float expired", ACT, 32'h1, 32'h0);
      rd("float logged", `PSA_OFS_UNVIEWED, 32'h1, 32'h1);
      lamp_hi();
      check("lamp steady", 32'd16, hi);
      check("slot kept", 32'h1, slot_shown[0]);
      check("irq", 32'h1, irq);
      view();
      rd("log purged", `PSA_OFS_UNVIEWED, 32'h7FF, 32'h0);
      bus(1'b1, `PSA_OFS_IRQ_STATUS, 32'h7FF);
      rd("status", `PSA_OFS_IRQ_STATUS, 32'h7FF, 32'h0);
      @(negedge core_clk);
      check("irq", 32'h0, irq);
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         fault <= fset[i];
         depth <= (i == 6) ? 3'h4 : 3'h0;
         {low_level_in, stop_fail_in} <= {2{i == 7}};
         settle(6);
         rd("active", ACT, 32'h7FF, etab[i]);
         @(negedge core_clk);
         if (i == 2 || i == 7) begin
            check("pair", (i == 2) ? 32'h40 : 32'h06, slot_second);
         end
      end
      @(posedge core_clk);
      fault <= 6'h00;
      depth <= 3'h0;
      {low_level_in, stop_fail_in} <= 2'b00;
      bus(1'b1, `PSA_OFS_CTRL, 32'hD);
      bus(1'b1, `PSA_OFS_HIGH_SP, 32'd100);
      bus(1'b1, `PSA_OFS_OVER_SP, 32'd500);
      bus(1'b1, `PSA_OFS_UNDER_SP, 32'd100);
      level_value <= 16'd101;
      pump_auto_req <= 3'h7;
      volts.line_ab <= 16'd501;
      settle(6);
      rd("analog high", ACT, 32'h508, 32'h508);
      rd("outputs", OUTS, 32'h3E, 32'h06);
      hand <= 3'h1;
      settle(6);
      rd("hand", OUTS, 32'h38, 32'h08);
      hand <= 3'h0;
      level_value <= 16'd100;
      volts.line_ab <= 16'd99;
      settle(6);
      rd("low volts", ACT, 32'h108, 32'h100);
      volts.line_ab <= 16'd500;
      settle(6);
      rd("volts ok", ACT, 32'h100, 32'h0);
      tally_and_finish();
   end
endmodule // psa_annunciator_bench

`default_nettype wire
